/* verilog/asuart_pkg.sv */
package asuart_pkg;
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] ADDR_DATA     = 12'hf40;
  localparam logic [11:0] ADDR_STATUS   = 12'hf41;
  localparam logic [11:0] ADDR_CTRL0    = 12'hf42;
  localparam logic [11:0] ADDR_DIV_HI   = 12'hf43;
  localparam logic [11:0] ADDR_DIV_LO   = 12'hf44;
  localparam logic [11:0] ADDR_CTRL1    = 12'hf45;
  localparam logic [7:0]  CTRL0_RESET   = 8'h00;
  localparam logic [7:0]  CTRL1_RESET   = 8'h00;
  localparam logic [15:0] DIV_RESET     = 16'h0000;
  // Control 0 bit positions
  localparam int C0_TX_EN   = 7;
  localparam int C0_RX_EN   = 6;
  localparam int C0_FLOW    = 5;
  localparam int C0_PAR_ON  = 4;
  localparam int C0_PAR_ODD = 3;
  localparam int C0_BREAK   = 2;
  localparam int C0_STOP2   = 1;
  localparam int C0_LOOP    = 0;
  // Control 1 bit positions
  localparam int C1_MP_ON   = 0;
  localparam int C1_TIMER   = 1;
  localparam int C1_TX_NINE = 2;
  localparam int C1_SCHEME  = 3;
  localparam int C1_TIM_HIT = 6;
  localparam int C1_RX_NINE = 7;
  localparam logic [7:0] C1_WR_MASK = 8'h1f;
  // Samples per bit and the mid-bit point of the start bit
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] OVS_MID  = 4'h7;
  localparam logic [2:0] BIT_LAST = 3'h7;
  typedef enum logic [2:0] {
    ASU_IDLE  = 3'b000,
    ASU_START = 3'b001,
    ASU_DATA  = 3'b010,
    ASU_PAR   = 3'b011,
    ASU_NINTH = 3'b100,
    ASU_STOP  = 3'b101
  } asuart_state_t;
endpackage

/* verilog/asuart_core.sv */
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
module asuart_core (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic [asuart_pkg::ADDR_W-1:0] addr,
  input  wire logic [7:0]                   wdata,
  input  wire logic                         wr,
  input  wire logic                         rd,
  output logic      [7:0]                   rdata,
  input  wire logic                         rxd,
  input  wire logic                         cts_n,
  output logic                              txd,
  output logic                              drv_en,
  output logic                              tx_irq,
  output logic                              rx_irq
);
  import asuart_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [7:0]    ctl0;
    logic [7:0]    ctl1;
    logic [15:0]   div;
    logic [15:0]   cnt;
    logic          tick;
    asuart_state_t tx_state;
    logic [3:0]    tx_sub;
    logic [2:0]    tx_bit;
    logic          tx_stop2;
    logic [7:0]    tx_shift;
    logic [7:0]    tx_hold;
    logic          tx_par;
    logic          hold_empty;
    asuart_state_t rx_state;
    logic [3:0]    rx_sub;
    logic [2:0]    rx_bit;
    logic [7:0]    rx_shift;
    logic          rx_par;
    logic          rx_nine;
    logic          rx_zero;
    logic [7:0]    rx_data;
    logic          receive_data_available;
    logic          pe;
    logic          oe;
    logic          fe;
    logic          brk;
    logic [7:0]    rdata;
    logic          txd;
    logic          de;
    logic          tx_irq;
    logic          rx_irq;
  } asuart_regs_t;

  asuart_regs_t s_r;
  asuart_regs_t s_nxt;

  function automatic logic par_bit(input logic [7:0] d, input logic odd);
    par_bit = (^d) ^ odd;
  endfunction

  logic tx_en;
  logic rx_in;
  logic rx_done;
  logic rx_keep;
  logic rd_clr;
  logic tx_start;

  assign rdata  = s_r.rdata;
  assign txd    = s_r.txd;
  assign drv_en = s_r.de;
  assign tx_irq = s_r.tx_irq;
  assign rx_irq = s_r.rx_irq;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    s_nxt = s_r;
    tx_en = s_r.ctl0[C0_TX_EN] & (~s_r.ctl0[C0_FLOW] | ~cts_n);
    // Loopback feeds the transmitter straight back, line ignored
    rx_in = s_r.ctl0[C0_LOOP] ? s_r.txd : rxd;
    rd_clr = rd && (addr == ADDR_DATA);
    rx_done = 1'b0;
    rx_keep = 1'b0;
    tx_start = 1'b0;

    // Shared divider: tick is the 16x sample enable
    s_nxt.tick = 1'b0;
    if (s_r.div != 16'h0000) begin
      if (s_r.cnt <= 16'h0001) begin
        s_nxt.cnt = s_r.div;
        s_nxt.tick = ~s_r.ctl1[C1_TIMER];
        if (s_r.ctl1[C1_TIMER]) begin
          s_nxt.ctl1[C1_TIM_HIT] = 1'b1;
        end
      end else begin
        s_nxt.cnt = s_r.cnt - 16'h0001;
      end
    end

    // Register writes; flags set by hardware are applied later and win
    if (wr) begin
      case (addr)
        ADDR_DATA: begin
          s_nxt.tx_hold = wdata;
          s_nxt.hold_empty = 1'b0;
        end
        ADDR_CTRL0: s_nxt.ctl0 = wdata;
        ADDR_DIV_HI: begin
          s_nxt.div[15:8] = wdata;
          s_nxt.cnt = 16'h0000;
        end
        ADDR_DIV_LO: begin
          s_nxt.div[7:0] = wdata;
          s_nxt.cnt = 16'h0000;
        end
        ADDR_CTRL1: begin
          s_nxt.ctl1[4:0] = wdata[4:0] & C1_WR_MASK[4:0];
          if (wdata[C1_TIM_HIT]) begin
            s_nxt.ctl1[C1_TIM_HIT] = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (s_r.ctl1[C1_TIMER] && s_r.div != 16'h0000
        && s_r.cnt <= 16'h0001) begin
      s_nxt.ctl1[C1_TIM_HIT] = 1'b1;
    end

    // ************************************************************
    // Transmitter
    // ************************************************************
    if (s_r.tx_state == ASU_IDLE) begin
      if (tx_en && !s_r.hold_empty && !s_r.ctl0[C0_BREAK]) begin
        tx_start = 1'b1;
        s_nxt.tx_shift = s_r.tx_hold;
        s_nxt.tx_par = par_bit(s_r.tx_hold, s_r.ctl0[C0_PAR_ODD]);
        s_nxt.hold_empty = 1'b1;
        s_nxt.tx_state = ASU_START;
        s_nxt.tx_sub = 4'h0;
        s_nxt.tx_bit = 3'h0;
        s_nxt.tx_stop2 = 1'b0;
      end
    end else if (s_r.tick) begin
      s_nxt.tx_sub = s_r.tx_sub + 4'h1;
      if (s_r.tx_sub == OVS_LAST) begin
        case (s_r.tx_state)
          ASU_START: s_nxt.tx_state = ASU_DATA;
          ASU_DATA: begin
            s_nxt.tx_shift = {1'b0, s_r.tx_shift[7:1]};
            s_nxt.tx_bit = s_r.tx_bit + 3'h1;
            if (s_r.tx_bit == BIT_LAST) begin
              if (s_r.ctl0[C0_PAR_ON]) begin
                s_nxt.tx_state = ASU_PAR;
              end else if (s_r.ctl1[C1_MP_ON]) begin
                s_nxt.tx_state = ASU_NINTH;
              end else begin
                s_nxt.tx_state = ASU_STOP;
              end
            end
          end
          ASU_PAR: begin
            s_nxt.tx_state = s_r.ctl1[C1_MP_ON] ? ASU_NINTH : ASU_STOP;
          end
          ASU_NINTH: s_nxt.tx_state = ASU_STOP;
          ASU_STOP: begin
            if (s_r.ctl0[C0_STOP2] && !s_r.tx_stop2) begin
              s_nxt.tx_stop2 = 1'b1;
            end else begin
              s_nxt.tx_state = ASU_IDLE;
            end
          end
          default: s_nxt.tx_state = ASU_IDLE;
        endcase
      end
    end
    // Break aborts the frame; the held byte stays for later
    if (s_r.ctl0[C0_BREAK]) begin
      s_nxt.tx_state = ASU_IDLE;
    end
    case (s_nxt.tx_state)
      ASU_START: s_nxt.txd = 1'b0;
      ASU_DATA:  s_nxt.txd = s_nxt.tx_shift[0];
      ASU_PAR:   s_nxt.txd = s_nxt.tx_par;
      ASU_NINTH: s_nxt.txd = s_r.ctl1[C1_TX_NINE];
      default:   s_nxt.txd = 1'b1;
    endcase
    if (s_r.ctl0[C0_BREAK]) begin
      s_nxt.txd = 1'b0;
    end
    s_nxt.de = (s_nxt.tx_state != ASU_IDLE);

    // ************************************************************
    // Receiver
    // ************************************************************
    if (rd_clr) begin
      s_nxt.receive_data_available = 1'b0;
      s_nxt.pe = 1'b0;
      s_nxt.oe = 1'b0;
      s_nxt.fe = 1'b0;
      s_nxt.brk = 1'b0;
    end
    if (!s_r.ctl0[C0_RX_EN]) begin
      s_nxt.rx_state = ASU_IDLE;
    end else begin
      case (s_r.rx_state)
        ASU_IDLE: begin
          if (!rx_in) begin
            s_nxt.rx_state = ASU_START;
            s_nxt.rx_sub = 4'h0;
          end
        end
        ASU_START: begin
          if (s_r.tick) begin
            s_nxt.rx_sub = s_r.rx_sub + 4'h1;
            if (s_r.rx_sub == OVS_MID) begin
              // A start bit gone high by mid-bit was a glitch
              s_nxt.rx_state = rx_in ? ASU_IDLE : ASU_DATA;
              s_nxt.rx_sub = 4'h0;
              s_nxt.rx_bit = 3'h0;
              s_nxt.rx_zero = 1'b1;
              s_nxt.rx_par = 1'b0;
              s_nxt.rx_nine = 1'b0;
            end
          end
        end
        default: begin
          if (s_r.tick) begin
            s_nxt.rx_sub = s_r.rx_sub + 4'h1;
            if (s_r.rx_sub == OVS_LAST) begin
              s_nxt.rx_zero = s_r.rx_zero & ~rx_in;
              case (s_r.rx_state)
                ASU_DATA: begin
                  s_nxt.rx_shift = {rx_in, s_r.rx_shift[7:1]};
                  s_nxt.rx_bit = s_r.rx_bit + 3'h1;
                  if (s_r.rx_bit == BIT_LAST) begin
                    if (s_r.ctl0[C0_PAR_ON]) begin
                      s_nxt.rx_state = ASU_PAR;
                    end else if (s_r.ctl1[C1_MP_ON]) begin
                      s_nxt.rx_state = ASU_NINTH;
                    end else begin
                      s_nxt.rx_state = ASU_STOP;
                    end
                  end
                end
                ASU_PAR: begin
                  s_nxt.rx_par = rx_in;
                  s_nxt.rx_state = s_r.ctl1[C1_MP_ON] ? ASU_NINTH : ASU_STOP;
                end
                ASU_NINTH: begin
                  s_nxt.rx_nine = rx_in;
                  s_nxt.rx_state = ASU_STOP;
                end
                default: begin
                  // Only the first stop bit is checked
                  rx_done = 1'b1;
                  s_nxt.rx_state = ASU_IDLE;
                end
              endcase
            end
          end
        end
      endcase
    end
    if (rx_done) begin
      // Scheme 00 all, 01 address (ninth=1) only, 10 data only
      case (s_r.ctl1[C1_SCHEME +: 2])
        2'b01:   rx_keep = ~s_r.ctl1[C1_MP_ON] | s_r.rx_nine;
        2'b10:   rx_keep = ~s_r.ctl1[C1_MP_ON] | ~s_r.rx_nine;
        default: rx_keep = 1'b1;
      endcase
    end
    if (rx_keep) begin
      s_nxt.rx_data = s_r.rx_shift;
      s_nxt.ctl1[C1_RX_NINE] = s_r.rx_nine;
      s_nxt.receive_data_available = 1'b1;
      s_nxt.oe = (s_r.oe & ~rd_clr) | (s_r.receive_data_available & ~rd_clr);
      s_nxt.pe = s_r.ctl0[C0_PAR_ON] &&
                 (s_r.rx_par != par_bit(s_r.rx_shift, s_r.ctl0[C0_PAR_ODD]));
      s_nxt.fe = ~rx_in;
      s_nxt.brk = s_r.rx_zero & ~rx_in;
    end

    // ************************************************************
    // Register reads and interrupt requests
    // ************************************************************
    s_nxt.rdata = 8'h00;
    if (rd) begin
      case (addr)
        ADDR_DATA:   s_nxt.rdata = s_r.rx_data;
        ADDR_STATUS: s_nxt.rdata = {s_r.receive_data_available, s_r.pe, s_r.oe, s_r.fe, s_r.brk,
                                    s_r.hold_empty,
                                    s_r.hold_empty &&
                                    (s_r.tx_state == ASU_IDLE),
                                    cts_n};
        ADDR_CTRL0:  s_nxt.rdata = s_r.ctl0;
        ADDR_DIV_HI: s_nxt.rdata = s_r.div[15:8];
        ADDR_DIV_LO: s_nxt.rdata = s_r.div[7:0];
        ADDR_CTRL1:  s_nxt.rdata = s_r.ctl1;
        default:     s_nxt.rdata = 8'h00;
      endcase
    end
    s_nxt.tx_irq = (s_nxt.hold_empty & s_r.ctl0[C0_TX_EN]) |
                   s_nxt.ctl1[C1_TIM_HIT];
    s_nxt.rx_irq = s_nxt.receive_data_available | s_nxt.pe | s_nxt.oe | s_nxt.fe | s_nxt.brk;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.ctl0 <= CTRL0_RESET;
      s_r.ctl1 <= CTRL1_RESET;
      s_r.div <= DIV_RESET;
      s_r.tx_state <= ASU_IDLE;
      s_r.rx_state <= ASU_IDLE;
      s_r.hold_empty <= 1'b1;
      s_r.txd <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_flow_gate;
    (s_r.tx_state == ASU_IDLE && s_r.ctl0[C0_FLOW] && cts_n)
      |=> (s_r.tx_state == ASU_IDLE);
  endproperty
  a_flow_gate: assert property (p_flow_gate)
    else $error("transmit started while clear-to-send high");

  property p_flow_off;
    (s_r.tx_state == ASU_IDLE && !s_r.ctl0[C0_FLOW] && s_r.ctl0[C0_TX_EN]
     && !s_r.hold_empty && !s_r.ctl0[C0_BREAK])
      |=> (s_r.tx_state == ASU_START) && !txd && drv_en;
  endproperty
  a_flow_off: assert property (p_flow_off)
    else $error("transmit did not start with gating off");

  property p_tx_off;
    (s_r.tx_state == ASU_IDLE && !s_r.ctl0[C0_TX_EN])
      |=> (s_r.tx_state == ASU_IDLE);
  endproperty
  a_tx_off: assert property (p_tx_off)
    else $error("disabled transmitter started");

  property p_break;
    s_r.ctl0[C0_BREAK] |=> !txd && (s_r.tx_state == ASU_IDLE);
  endproperty
  a_break: assert property (p_break)
    else $error("break did not force line low");

  property p_rx_off;
    !s_r.ctl0[C0_RX_EN] |=> (s_r.rx_state == ASU_IDLE);
  endproperty
  a_rx_off: assert property (p_rx_off)
    else $error("disabled receiver left idle");

  property p_read_clear;
    (rd_clr && !rx_keep) |=> !s_r.receive_data_available && !s_r.fe && !s_r.brk && !s_r.oe;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("data read did not clear flags");

  property p_overrun;
    (rx_keep && s_r.receive_data_available && !rd_clr) |=> s_r.oe && s_r.receive_data_available && rx_irq;
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not flagged");

  property p_break_seen;
    rx_keep |=> (s_r.brk == ($past(s_r.rx_zero) && s_r.fe));
  endproperty
  a_break_seen: assert property (p_break_seen)
    else $error("break flag wrong");

  property p_reset_val;
    $past(rst) |-> s_r.hold_empty && !s_r.receive_data_available && !s_r.pe && txd && !drv_en;
  endproperty
  a_reset_val: assert property (p_reset_val)
    else $error("bad state after reset");

  c_tx_start: cover property (tx_start ##1 drv_en);
  c_rx_char: cover property (rx_keep ##1 rx_irq);
  c_break: cover property (rx_keep && s_r.rx_zero && !rx_in);
  c_overrun: cover property (rx_keep && s_r.receive_data_available);
endmodule

/* verification/asuart_remote.sv */
`timescale 1ns/1ps
// ****************************************
// Remote serial station, divider of 1
// ****************************************
module asuart_remote (
  input  wire logic clk,
  input  wire logic txd,
  output logic      rxd
);
  // Line rests high between frames, driven by this station
  initial rxd = 1'b1;

  task automatic send(input logic [7:0] d, input bit has_par,
                      input logic par, input logic stp);
    logic [10:0] f;
    int          n;
    f = has_par ? {stp, par, d, 1'b0} : {1'b1, stp, d, 1'b0};
    n = has_par ? 11 : 10;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rxd <= f[i];
      repeat (15) @(posedge clk);
    end
    @(posedge clk);
    rxd <= 1'b1;
  endtask

  // Samples mid-bit; the wait for a start edge is bounded
  task automatic recv(output logic [9:0] b, output bit ok);
    ok = 1'b0;
    b = '0;
    for (int i = 0; i < 2000 && txd !== 1'b0; i++) @(posedge clk);
    if (txd === 1'b0) begin
      repeat (8) @(posedge clk);
      ok = (txd === 1'b0);
      for (int i = 0; i < 10; i++) begin
        repeat (16) @(posedge clk);
        b[i] = txd;
      end
    end
  endtask
endmodule

/* verification/async_serial_uart_core_tb.sv */
`timescale 1ns/1ps
module async_serial_uart_core_tb;
  import asuart_pkg::*;
  logic              clk;
  logic              rst;
  logic [ADDR_W-1:0] addr;
  logic [7:0]        wdata;
  logic              wr;
  logic              rd;
  logic [7:0]        rdata;
  logic              rxd;
  logic              cts_n;
  logic              txd;
  logic              drv_en;
  logic              tx_irq;
  logic              rx_irq;
  int                fail_count = 0;
  int                checks_done = 0;
  int                de_cnt = 0;
  int                lo_cnt = 0;
  int                cyc = 0;
  logic [31:0]       seed = 32'hd37c;

  asuart_core dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd), .cts_n(cts_n),
    .txd(txd), .drv_en(drv_en), .tx_irq(tx_irq), .rx_irq(rx_irq));
  asuart_remote rem (.clk(clk), .txd(txd), .rxd(rxd));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (drv_en === 1'b1) de_cnt <= de_cnt + 1;
    if (txd === 1'b0) lo_cnt <= lo_cnt + 1;
    cyc <= cyc + 1;
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] rnd8();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e,
                      input string m);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    logic [7:0] g;
    rd_reg(a, g);
    chk8(g, e, "register read");
  endtask

  // A hung transmitter ends the run rather than stalling it
  task automatic tx_wait();
    for (int i = 0; i < 400 && drv_en !== 1'b0; i++) @(posedge clk);
    chk8({7'h0, drv_en}, 8'h00, "transmitter hung");
    if (drv_en !== 1'b0) tally_and_finish();
  endtask

  // ****************************************
  // Frame models
  // ****************************************
  task automatic tx_check(input logic [7:0] c, input logic [7:0] d);
    logic [9:0] fr;
    logic       p;
    bit         ok;
    int         n0;
    n0 = de_cnt;
    p = c[4] ? ^d ^ c[3] : 1'b1;
    rem.recv(fr, ok);
    chk8({7'h0, ok}, 8'h01, "start bit");
    chk8(fr[7:0], d, "tx data");
    chk8({7'h0, fr[8]}, {7'h0, p}, "tx parity");
    chk8({7'h0, fr[9]}, 8'h01, "tx stop");
    tx_wait();
    n0 = 16 * (10 + c[4] + c[1]) - (de_cnt - n0);
    chk8(8'(n0), 8'h00, "driver enable span");
  endtask

  task automatic rx_check(input logic [7:0] c, input logic [7:0] d,
                          input logic pbad, input logic stp,
                          input logic oe);
    logic       p;
    logic       brk;
    logic [7:0] e;
    logic [7:0] g;
    p = ^d ^ c[3] ^ pbad;
    brk = (d == 8'h00) && !(c[4] && p) && !stp;
    e = {c[6], c[6] & c[4] & pbad, oe, c[6] & !stp, c[6] & brk,
         2'b11, cts_n};
    rem.send(d, c[4], p, stp);
    tx_wait();
    repeat (4) @(posedge clk);
    chk8({7'h0, rx_irq}, {7'h0, c[6]}, "rx irq");
    rd_chk(ADDR_STATUS, e);
    if (c[6]) begin
      rd_reg(ADDR_DATA, g);
      if (!oe) chk8(g, d, "rx data");
      rd_chk(ADDR_STATUS, {5'h00, 2'b11, cts_n});
    end
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    logic [7:0] c;
    logic [7:0] v;
    int         n;
    rst = 1'b1;
    addr = '0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    cts_n = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd_chk(ADDR_STATUS, 8'h06);
    rd_chk(ADDR_CTRL0, CTRL0_RESET);
    rd_chk(12'h000, 8'h00);
    wr_reg(ADDR_DIV_HI, 8'h00);
    wr_reg(ADDR_DIV_LO, 8'h01);
    // Every parity and stop setting, both directions at once
    for (int f = 0; f < 8; f++) begin
      c = {3'b110, f[0], f[1], 1'b0, f[2], 1'b0};
      wr_reg(ADDR_CTRL0, 8'h00);
      wr_reg(ADDR_CTRL0, c);
      repeat (2) @(posedge clk);
      chk8({7'h0, tx_irq}, 8'h01, "tx irq");
      v = rnd8();
      wr_reg(ADDR_DATA, v);
      fork
        tx_check(c, v);
        rx_check(c, rnd8(), f[0] & f[1], 1'b1, 1'b0);
      join
    end
    c = 8'h50;
    wr_reg(ADDR_CTRL0, 8'h00);
    wr_reg(ADDR_CTRL0, c);
    rx_check(c, rnd8() | 8'h01, 1'b0, 1'b0, 1'b0);
    rx_check(c, 8'h00, 1'b0, 1'b0, 1'b0);
    rem.send(8'h5a, 1'b1, 1'b0, 1'b1);
    rx_check(c, 8'ha5, 1'b0, 1'b1, 1'b1);
    wr_reg(ADDR_CTRL0, 8'h00);
    wr_reg(ADDR_CTRL0, 8'h80);
    rx_check(8'h80, rnd8(), 1'b0, 1'b1, 1'b0);
    // Flow gating: held byte waits for enable and clear-to-send
    wr_reg(ADDR_CTRL0, 8'h00);
    wr_reg(ADDR_CTRL0, 8'h20);
    v = rnd8();
    n = lo_cnt;
    wr_reg(ADDR_DATA, v);
    repeat (40) @(posedge clk);
    chk8(8'(lo_cnt - n), 8'h00, "sent while off");
    cts_n <= 1'b1;
    wr_reg(ADDR_CTRL0, 8'ha0);
    repeat (40) @(posedge clk);
    chk8(8'(lo_cnt - n), 8'h00, "sent while gated");
    rd_chk(ADDR_STATUS, 8'h01);
    cts_n <= 1'b0;
    tx_check(8'ha0, v);
    wr_reg(ADDR_CTRL0, 8'h00);
    wr_reg(ADDR_CTRL0, 8'h80);
    cts_n <= 1'b1;
    v = rnd8();
    wr_reg(ADDR_DATA, v);
    tx_check(8'h80, v);
    // Multiprocessor: scheme 01 keeps only characters with ninth bit set
    wr_reg(ADDR_CTRL0, 8'h00);
    wr_reg(ADDR_CTRL1, 8'h09);
    wr_reg(ADDR_CTRL0, 8'h40);
    rem.send(8'h3c, 1'b1, 1'b0, 1'b1);
    repeat (2) @(posedge clk);
    rd_chk(ADDR_STATUS, {5'h00, 2'b11, cts_n});
    rem.send(8'hc3, 1'b1, 1'b1, 1'b1);
    repeat (2) @(posedge clk);
    rd_chk(ADDR_STATUS, {5'h10, 2'b11, cts_n});
    rd_chk(ADDR_CTRL1, 8'h89);
    rd_chk(ADDR_DATA, 8'hc3);
    // Loopback: the receiver hears the transmitter, line ignored
    wr_reg(ADDR_CTRL0, 8'h00);
    wr_reg(ADDR_CTRL1, 8'h00);
    wr_reg(ADDR_CTRL0, 8'hc1);
    v = rnd8();
    wr_reg(ADDR_DATA, v);
    repeat (2) @(posedge clk);
    tx_wait();
    rd_chk(ADDR_DATA, v);
    // Timer: hit flag recurs every divider period and drives tx_irq
    wr_reg(ADDR_CTRL0, 8'h00);
    wr_reg(ADDR_DIV_LO, 8'h20);
    wr_reg(ADDR_CTRL1, 8'h42);
    for (int i = 0; i < 64 && tx_irq !== 1'b1; i++) @(posedge clk);
    n = cyc;
    wr_reg(ADDR_CTRL1, 8'h42);
    @(posedge clk);
    chk8({7'h0, tx_irq}, 8'h00, "timer clear");
    for (int i = 0; i < 64 && tx_irq !== 1'b1; i++) @(posedge clk);
    chk8(8'(cyc - n), 8'h20, "timer period");
    wr_reg(ADDR_CTRL1, 8'h40);
    wr_reg(ADDR_DIV_LO, 8'h01);
    wr_reg(ADDR_CTRL0, 8'h80);
    // Break cuts a character short; kept last as its tail is open
    wr_reg(ADDR_DATA, rnd8() | 8'h01);
    repeat (40) @(posedge clk);
    wr_reg(ADDR_CTRL0, 8'h00);
    wr_reg(ADDR_CTRL0, 8'h84);
    repeat (2) @(posedge clk);
    n = lo_cnt;
    repeat (32) @(posedge clk);
    chk8(8'(lo_cnt - n), 8'd32, "break level");
    tally_and_finish();
  end
endmodule
